// ---- inc/stm_pkg.sv ----
// constants of the standard timer: register map, fields, codes
package stm_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int CNT_W  = 16;
	localparam int RP_W   = 8;

	// register offsets
	localparam logic [2:0] OFS_CTRL0  = 3'h0;
	localparam logic [2:0] OFS_CTRL1  = 3'h1;
	localparam logic [2:0] OFS_CNT_L  = 3'h2;
	localparam logic [2:0] OFS_CNT_H  = 3'h3;
	localparam logic [2:0] OFS_CMPA_L = 3'h4;
	localparam logic [2:0] OFS_CMPA_H = 3'h5;
	localparam logic [2:0] OFS_PERIOD = 3'h6;

	// control 0 fields
	localparam int C0_PAUSE = 7;
	localparam int C0_CKS_H = 6;
	localparam int C0_CKS_L = 4;
	localparam int C0_RUN   = 3;

	// control 1 fields
	localparam int C1_MODE_H = 7;
	localparam int C1_MODE_L = 6;
	localparam int C1_PIN_H  = 5;
	localparam int C1_PIN_L  = 4;
	localparam int C1_OC     = 3;
	localparam int C1_POL    = 2;
	localparam int C1_DPX    = 1;
	localparam int C1_CCLR   = 0;

	localparam logic [7:0] CTRL_RESET = 8'h00;

	// operating_mode_field codes
	localparam logic [1:0] MODE_CMP = 2'h0;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TC  = 2'h3;

	// pin_function_field codes
	localparam logic [1:0] PF_0 = 2'h0;
	localparam logic [1:0] PF_1 = 2'h1;
	localparam logic [1:0] PF_2 = 2'h2;
	localparam logic [1:0] PF_3 = 2'h3;

	// count_clock_select codes
	localparam logic [2:0] CKS_SYS4  = 3'h0;
	localparam logic [2:0] CKS_SYS   = 3'h1;
	localparam logic [2:0] CKS_H16   = 3'h2;
	localparam logic [2:0] CKS_H64   = 3'h3;
	localparam logic [2:0] CKS_SUB0  = 3'h4;
	localparam logic [2:0] CKS_SUB1  = 3'h5;
	localparam logic [2:0] CKS_EXT_R = 3'h6;
	localparam logic [2:0] CKS_EXT_F = 3'h7;

	// divider ratios
	localparam logic [1:0] SYS4_LAST = 2'h3;
	localparam logic [3:0] H16_LAST  = 4'hf;
	localparam logic [5:0] H64_LAST  = 6'h3f;
endpackage

// ---- verilog/stm_timer.sv ----
// standard 16-bit timer: registers, count clock select, compare and pin logic
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module stm_timer #(
	parameter int CNT_W = stm_pkg::CNT_W,
	parameter int RP_W  = stm_pkg::RP_W
) (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic [2:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       fh_tick,
	input  wire logic       fsub_tick,
	input  wire logic       external_count_pin,
	output logic            timer_output_pin,
	output logic            timer_output_oe,
	output logic            match_a_pulse,
	output logic            match_p_pulse
);

	// byte lanes and the P comparator are laid out for these widths only
	if (CNT_W != stm_pkg::CNT_W || RP_W != stm_pkg::RP_W) begin : g_width_check
		$error("counter or period width not supported");
	end

	// control and data registers
	logic       pause_reg;
	logic [2:0] cks_reg;
	logic       run_reg;
	logic       run_prev_reg;
	logic [7:0] ctrl1_reg;
	logic [7:0] rp_reg;
	logic [15:0] cmpa_reg;
	logic [7:0] buf_reg;
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	// clock enables
	logic [1:0] div4_reg;
	logic [5:0] divh_reg;
	logic [2:0] ext_sync_reg;
	logic       ext_level_reg;

	// pin state and match pulses
	logic       cm_level_reg;
	logic       cm_level_next;
	logic       pin_reg;
	logic       oe_reg;
	logic       ma_reg;
	logic       mp_reg;

	// field views
	wire logic [1:0] mode_w = ctrl1_reg[stm_pkg::C1_MODE_H:stm_pkg::C1_MODE_L];
	wire logic [1:0] pf_w   = ctrl1_reg[stm_pkg::C1_PIN_H:stm_pkg::C1_PIN_L];
	wire logic       oc_w   = ctrl1_reg[stm_pkg::C1_OC];
	wire logic       pol_w  = ctrl1_reg[stm_pkg::C1_POL];
	wire logic       dpx_w  = ctrl1_reg[stm_pkg::C1_DPX];
	wire logic       cclr_w = ctrl1_reg[stm_pkg::C1_CCLR];

	wire logic is_cmp = (mode_w == stm_pkg::MODE_CMP);
	wire logic is_pwm = (mode_w == stm_pkg::MODE_PWM);
	wire logic is_tc  = (mode_w == stm_pkg::MODE_TC);
	wire logic is_sp  = is_pwm && (pf_w == stm_pkg::PF_3);

	// register decode
	wire logic wr_c0  = reg_wr && (reg_addr == stm_pkg::OFS_CTRL0);
	wire logic wr_c1  = reg_wr && (reg_addr == stm_pkg::OFS_CTRL1);
	wire logic wr_al  = reg_wr && (reg_addr == stm_pkg::OFS_CMPA_L);
	wire logic wr_ah  = reg_wr && (reg_addr == stm_pkg::OFS_CMPA_H);
	wire logic wr_rp  = reg_wr && (reg_addr == stm_pkg::OFS_PERIOD);
	wire logic rd_ch  = reg_rd && (reg_addr == stm_pkg::OFS_CNT_H);
	wire logic rd_ah  = reg_rd && (reg_addr == stm_pkg::OFS_CMPA_H);

	// count clock enables
	wire logic tick_sys4 = (div4_reg == stm_pkg::SYS4_LAST);
	wire logic tick_h16  = fh_tick && (divh_reg[3:0] == stm_pkg::H16_LAST);
	wire logic tick_h64  = fh_tick && (divh_reg == stm_pkg::H64_LAST);
	// a pin change counts once the second and third stages agree, so a
	// one-cycle glitch that never sits in both at once is not counted
	wire logic ext_agree = (ext_sync_reg[1] == ext_sync_reg[2]);
	wire logic ext_rise  = ext_agree && ext_sync_reg[2] && !ext_level_reg;
	wire logic ext_fall  = ext_agree && !ext_sync_reg[2] && ext_level_reg;

	logic sel_tick;
	always_comb begin
		case (cks_reg)
			stm_pkg::CKS_SYS4:  sel_tick = tick_sys4;
			stm_pkg::CKS_SYS:   sel_tick = 1'b1;
			stm_pkg::CKS_H16:   sel_tick = tick_h16;
			stm_pkg::CKS_H64:   sel_tick = tick_h64;
			stm_pkg::CKS_SUB0,
			stm_pkg::CKS_SUB1:  sel_tick = fsub_tick;
			stm_pkg::CKS_EXT_R: sel_tick = ext_rise;
			stm_pkg::CKS_EXT_F: sel_tick = ext_fall;
			default:            sel_tick = 1'b0;
		endcase
	end

	wire logic run_rise = run_reg && !run_prev_reg;
	// the first cycle after the rise only clears, counting starts after
	wire logic cnt_en   = run_reg && !run_rise && !pause_reg && sel_tick;
	wire logic [15:0] cnt_inc = cnt_reg + 16'h0001;

	// comparators look at the value the counter moves to
	wire logic hit_a    = cnt_en && (cnt_inc == cmpa_reg);
	wire logic rp_zero  = (rp_reg == 8'h00);
	wire logic ovf      = cnt_en && (cnt_reg == 16'hffff);
	wire logic hit_p    = cnt_en && !rp_zero &&
	                      (cnt_inc[15:8] == rp_reg) && (cnt_inc[7:0] == 8'h00);
	wire logic p_event  = hit_p || (rp_zero && ovf);

	// clear selection
	logic clr_sel;
	always_comb begin
		if (is_pwm) begin
			clr_sel = dpx_w ? hit_a : p_event;
		end else begin
			clr_sel = cclr_w ? hit_a : p_event;
		end
	end

	always_comb begin
		if (run_rise) begin
			cnt_next = 16'h0000;
		end else if (cnt_en && clr_sel) begin
			cnt_next = 16'h0000;
		end else if (cnt_en) begin
			cnt_next = cnt_inc;
		end else begin
			cnt_next = cnt_reg;
		end
	end

	// PWM duty: the 17-bit reach lets a zero P byte stand for 65536
	wire logic [16:0] duty_w = dpx_w ?
	                           (rp_zero ? 17'h10000 : {1'b0, rp_reg, 8'h00}) :
	                           {1'b0, cmpa_reg};
	wire logic pwm_on = ({1'b0, cnt_reg} < duty_w);

	// compare mode level
	always_comb begin
		cm_level_next = cm_level_reg;
		if (run_rise) begin
			cm_level_next = oc_w;
		end else if (hit_a) begin
			case (pf_w)
				stm_pkg::PF_0: cm_level_next = cm_level_reg;
				stm_pkg::PF_1: cm_level_next = 1'b0;
				stm_pkg::PF_2: cm_level_next = 1'b1;
				stm_pkg::PF_3: cm_level_next = !cm_level_reg;
				default:       cm_level_next = cm_level_reg;
			endcase
		end
	end

	// pin level before polarity
	logic raw_level;
	always_comb begin
		if (is_cmp) begin
			raw_level = cm_level_reg;
		end else if (is_pwm) begin
			case (pf_w)
				stm_pkg::PF_0: raw_level = !oc_w;
				stm_pkg::PF_1: raw_level = oc_w;
				stm_pkg::PF_2: raw_level = pwm_on ? oc_w : !oc_w;
				stm_pkg::PF_3: raw_level = run_reg ? oc_w : !oc_w;
				default:       raw_level = !oc_w;
			endcase
		end else begin
			raw_level = 1'b0;
		end
	end

	// read mux; low bytes come from the shared buffer
	always_comb begin
		case (reg_addr)
			stm_pkg::OFS_CTRL0:  rdata_next = {pause_reg, cks_reg, run_reg, 3'h0};
			stm_pkg::OFS_CTRL1:  rdata_next = ctrl1_reg;
			stm_pkg::OFS_CNT_L:  rdata_next = buf_reg;
			stm_pkg::OFS_CNT_H:  rdata_next = cnt_reg[15:8];
			stm_pkg::OFS_CMPA_L: rdata_next = buf_reg;
			stm_pkg::OFS_CMPA_H: rdata_next = cmpa_reg[15:8];
			stm_pkg::OFS_PERIOD: rdata_next = rp_reg;
			default:             rdata_next = 8'h00;
		endcase
	end

	// control 0 and run bit
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pause_reg    <= 1'b0;
			cks_reg      <= 3'h0;
			run_reg      <= 1'b0;
			run_prev_reg <= 1'b0;
		end else begin
			run_prev_reg <= run_reg;
			if (wr_c0) begin
				pause_reg <= reg_wdata[stm_pkg::C0_PAUSE];
				cks_reg   <= reg_wdata[stm_pkg::C0_CKS_H:stm_pkg::C0_CKS_L];
				run_reg   <= reg_wdata[stm_pkg::C0_RUN];
			end else if (is_sp && hit_a) begin
				// single pulse ends on A match
				run_reg <= 1'b0;
			end
		end
	end

	// remaining software registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1_reg <= stm_pkg::CTRL_RESET;
			rp_reg    <= 8'h00;
			cmpa_reg  <= 16'h0000;
		end else begin
			if (wr_c1) begin
				ctrl1_reg <= reg_wdata;
			end
			if (wr_rp) begin
				rp_reg <= reg_wdata;
			end
			if (wr_ah) begin
				cmpa_reg <= {reg_wdata, buf_reg};
			end
		end
	end

	// shared 8-bit low-byte buffer
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			buf_reg <= 8'h00;
		end else if (wr_al) begin
			buf_reg <= reg_wdata;
		end else if (rd_ch) begin
			buf_reg <= cnt_reg[7:0];
		end else if (rd_ah) begin
			buf_reg <= cmpa_reg[7:0];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	// dividers and pin synchroniser
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div4_reg      <= 2'h0;
			divh_reg      <= 6'h00;
			ext_sync_reg  <= 3'h0;
			ext_level_reg <= 1'b0;
		end else begin
			div4_reg     <= div4_reg + 2'h1;
			ext_sync_reg <= {ext_sync_reg[1:0], external_count_pin};
			if (ext_agree) begin
				ext_level_reg <= ext_sync_reg[2];
			end
			if (fh_tick) begin
				divh_reg <= divh_reg + 6'h01;
			end
		end
	end

	// counter
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 16'h0000;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// pin and match pulses
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cm_level_reg <= 1'b0;
			pin_reg      <= 1'b0;
			oe_reg       <= 1'b0;
			ma_reg       <= 1'b0;
			mp_reg       <= 1'b0;
		end else begin
			cm_level_reg <= cm_level_next;
			// timer/counter mode leaves the pin undriven
			pin_reg      <= is_tc ? 1'b0 : (raw_level ^ pol_w);
			oe_reg       <= is_cmp || is_pwm;
			ma_reg       <= hit_a;
			// P match is not reported while A clears in compare modes
			mp_reg       <= p_event && (is_pwm || !cclr_w);
		end
	end

	assign reg_rdata        = rdata_reg;
	assign timer_output_pin = pin_reg;
	assign timer_output_oe  = oe_reg;
	assign match_a_pulse    = ma_reg;
	assign match_p_pulse    = mp_reg;

endmodule

`default_nettype wire

// ---- verification/stm_timer_asserts.sv ----
// port-level checks of the standard timer, bound to the timer
`timescale 1ns/1ns
`default_nettype none
module stm_timer_asserts (
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       fh_tick,
	input wire logic       fsub_tick,
	input wire logic       external_count_pin,
	input wire logic       timer_output_pin,
	input wire logic       timer_output_oe,
	input wire logic       match_a_pulse,
	input wire logic       match_p_pulse
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// shadow of both control registers, rebuilt from bus writes
	logic [15:0] sh_reg;
	logic [1:0]  calm_reg;
	wire         wr0     = reg_wr && reg_addr == stm_pkg::OFS_CTRL0;
	wire         wr1     = reg_wr && reg_addr == stm_pkg::OFS_CTRL1;
	wire  [15:0] sh_next = {wr1 ? reg_wdata : sh_reg[15:8], wr0 ? reg_wdata : sh_reg[7:0]};
	// calm: no control change for three cycles, registered outputs have caught up
	wire         calm    = calm_reg == 2'h3;
	wire  [1:0]  mode    = sh_reg[15:14];
	wire  [1:0]  pf      = sh_reg[13:12];
	wire         lvl     = sh_reg[11] ^ sh_reg[10];
	wire         run     = sh_reg[3];
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_reg   <= 16'h0000;
			calm_reg <= 2'h0;
		end else begin
			sh_reg   <= sh_next;
			calm_reg <= (sh_next != sh_reg) ? 2'h0 : calm_reg + {1'b0, !calm};
		end
	end
	sequence s_run_start;
		wr0 && reg_wdata[3] && !run && calm && mode == stm_pkg::MODE_CMP;
	endsequence
	property p_run_start;
		s_run_start |-> ##3 timer_output_pin == lvl;
	endproperty
	a_run_start: assert property (p_run_start) else $error("start level wrong");
	property p_rd_idle;
		!$past(reg_rd) |-> reg_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_a_once;
		match_a_pulse |=> !match_a_pulse;
	endproperty
	a_a_once: assert property (p_a_once) else $error("match a too long");
	property p_p_once;
		match_p_pulse |=> !match_p_pulse;
	endproperty
	a_p_once: assert property (p_p_once) else $error("match p too long");
	property p_tc_idle;
		calm && mode == stm_pkg::MODE_TC |-> !timer_output_oe && !timer_output_pin;
	endproperty
	a_tc_idle: assert property (p_tc_idle) else $error("pin driven in counter mode");
	property p_cmp_drive;
		calm && run && mode == stm_pkg::MODE_CMP |-> timer_output_oe;
	endproperty
	a_cmp_drive: assert property (p_cmp_drive) else $error("pin not driven");
	property p_cclr_a;
		calm && mode == stm_pkg::MODE_CMP && sh_reg[8] |-> !match_p_pulse;
	endproperty
	a_cclr_a: assert property (p_cclr_a) else $error("p match with clear on a");
	property p_force;
		calm && run && mode == stm_pkg::MODE_PWM && !pf[1] |-> timer_output_pin == (pf[0] ? lvl : !lvl);
	endproperty
	a_force: assert property (p_force) else $error("forced level wrong");
endmodule
bind stm_timer stm_timer_asserts u_chk (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .fh_tick, .fsub_tick, .external_count_pin, .timer_output_pin, .timer_output_oe,
	.match_a_pulse, .match_p_pulse);
`default_nettype wire

// ---- verification/stm_ext_model.sv ----
// external circuit on the count pin: one slow pulse per request
`timescale 1ns/1ns
`default_nettype none
module stm_ext_model (
	input  wire logic core_clk,
	input  wire logic edge_req,
	output logic      external_count_pin
);
	initial external_count_pin = 1'b0;
	// held three cycles so the synchroniser sees both edges
	always @(posedge core_clk) begin
		if (edge_req) begin
			external_count_pin <= 1'b1;
			repeat (3) @(posedge core_clk);
			external_count_pin <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- verification/stm_timer_test.sv ----
// self-checking bench of the standard timer
`timescale 1ns/1ns
`default_nettype none
module stm_timer_test;
	logic       core_clk;
	logic       rst_n;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       fh_tick = 1'b0;
	logic       edge_req;
	logic       ext_pin;
	logic       pin;
	logic       oe;
	logic       hit_a;
	logic       hit_p;
	int         error_cnt = 0;
	int         compares = 0;
	stm_timer uut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fh_tick,
		.fsub_tick(fh_tick), .external_count_pin(ext_pin), .timer_output_pin(pin),
		.timer_output_oe(oe), .match_a_pulse(hit_a), .match_p_pulse(hit_p));
	stm_ext_model ext (.core_clk, .edge_req, .external_count_pin(ext_pin));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) fh_tick <= ~fh_tick;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge core_clk);
	endtask
	task automatic rd16(input logic [2:0] hi, output logic [15:0] v);
		rd(hi, v[15:8]);
		rd(hi - 3'h1, v[7:0]);
	endtask
	task automatic gap(input bit p, output int n);
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while ((p ? hit_p : hit_a) !== 1'b1 && n < 2000);
	endtask
	task automatic pulse();
		edge_req <= 1'b1;
		@(posedge core_clk);
		edge_req <= 1'b0;
		repeat (8) @(posedge core_clk);
	endtask
	task automatic t_regs();
		logic [7:0] d;
		logic [15:0] v;
		for (int i = 0; i < 8; i++) begin
			rd(3'(i), d);
			chk(16'(d), 16'h0000);
		end
		wr(3'h3, 8'hff);
		wr(3'h4, 8'h34);
		rd(3'h5, d);
		wr(3'h5, 8'h12);
		rd16(3'h5, v);
		chk(v, 16'h1200);
		rd(3'h3, d);
		chk(16'(d), 16'h0000);
	endtask
	task automatic t_toggle();
		int n;
		logic [15:0] v;
		logic [15:0] w;
		wr(3'h4, 8'h03);
		wr(3'h5, 8'h00);
		rd16(3'h5, v);
		chk(v, 16'h0003);
		wr(3'h1, 8'h31);
		repeat (4) @(posedge core_clk);
		wr(3'h0, 8'h18);
		gap(1'b0, n);
		// the pin follows the match pulse by one cycle
		@(posedge core_clk);
		chk(16'(pin), 16'h0001);
		gap(1'b0, n);
		chk(16'(n + 1), 16'h0003);
		@(posedge core_clk);
		chk(16'(pin), 16'h0000);
		wr(3'h0, 8'h10);
		rd16(3'h3, v);
		rd16(3'h3, w);
		chk(w, v);
	endtask
	task automatic t_ext();
		logic [15:0] v;
		for (int k = 6; k < 8; k++) begin
			wr(3'h0, 8'h00);
			wr(3'h1, 8'hc0);
			wr(3'h0, 8'(k * 16 + 8));
			repeat (5) pulse();
			wr(3'h0, 8'(k * 16 + 136));
			pulse();
			rd16(3'h3, v);
			chk(v, 16'h0005);
			chk(16'(oe), 16'h0000);
		end
	endtask
	task automatic t_period();
		int n;
		wr(3'h0, 8'h00);
		wr(3'h1, 8'h00);
		wr(3'h6, 8'h01);
		wr(3'h0, 8'h18);
		gap(1'b1, n);
		gap(1'b1, n);
		chk(16'(n), 16'h0100);
	endtask
	task automatic t_pwm();
		for (int i = 0; i < 8; i++) begin
			wr(3'h0, 8'h00);
			wr(3'h1, {2'b10, 1'b0, i[2], i[1], i[0], 2'b00});
			wr(3'h0, 8'h18);
			repeat (6) @(posedge core_clk);
			chk(16'(pin), 16'((i[2] ? i[1] : !i[1]) ^ i[0]));
		end
	endtask
	task automatic t_wave();
		int n;
		int hi;
		for (int d = 0; d < 2; d++) begin
			wr(3'h0, 8'h00);
			wr(3'h4, d[0] ? 8'h80 : 8'h40);
			wr(3'h5, {7'h00, d[0]});
			wr(3'h6, 8'h01);
			wr(3'h1, {6'b101010, d[0], 1'b1});
			wr(3'h0, 8'h18);
			gap(!d[0], n);
			gap(!d[0], n);
			chk(16'(n), d[0] ? 16'h0180 : 16'h0100);
			hi = 0;
			repeat (d[0] ? 384 : 256) begin
				@(posedge core_clk);
				if (pin === 1'b1) hi++;
			end
			chk(16'(hi), d[0] ? 16'h0100 : 16'h0040);
		end
	endtask
	task automatic t_pulse();
		int n;
		logic [7:0] d;
		wr(3'h0, 8'h00);
		wr(3'h4, 8'h10);
		wr(3'h5, 8'h00);
		wr(3'h1, 8'hb8);
		wr(3'h0, 8'h18);
		repeat (2) @(posedge core_clk);
		chk(16'(pin), 16'h0001);
		gap(1'b0, n);
		@(posedge core_clk);
		chk(16'(pin), 16'h0000);
		rd(3'h0, d);
		chk(16'(d), 16'h0010);
	endtask
	initial begin
		rst_n = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		edge_req = 1'b0;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_regs();
		t_toggle();
		t_ext();
		t_period();
		t_pwm();
		t_wave();
		t_pulse();
		give_verdict();
	end
	initial begin
		#400000;
		error_cnt++;
		give_verdict();
	end
endmodule
`default_nettype wire
